// ==== cpiu_unit.sv ====
/*
 cascadable eight-level vectored priority interrupt unit with an apb window
 for event flags and state read-back.
 assumes a same-clock microprogram controller on the instruction field, the
 m/s/vector bus levels resolved outside from the enables, request pins async.
*/
`timescale 1ns/1ps
module cpiu_unit #(
   parameter int unsigned LEVELS = cpiu_pkg::CPIU_LEVELS
) (
   input wire logic mclk, // 10 MHz clock
   input wire logic rst, // synchronous reset, high
   input wire logic instr_accept_n, // low: instruction field valid
   input wire logic [cpiu_pkg::CPIU_INSTR_W-1:0] instr_field, // microinstruction
   input wire logic [LEVELS-1:0] request_inputs_n, // async request pins, low asks
   input wire logic catcher_bypass, // high: latches transparent
   input wire logic [LEVELS-1:0] mask_bus_in, // mask bus level
   output logic [LEVELS-1:0] mask_bus_out, // mask register onto bus
   output logic mask_bus_oe, // driving mask bus
   input wire logic [cpiu_pkg::CPIU_VEC_W-1:0] status_bus_in, // status bus level
   output logic [cpiu_pkg::CPIU_VEC_W-1:0] status_bus_out, // status register onto bus
   output logic status_bus_oe, // driving status bus
   output logic [cpiu_pkg::CPIU_VEC_W-1:0] vector_out, // held vector
   output logic vector_oe, // driving vector lines
   input wire logic group_select_in, // high: group enabled from above
   input wire logic group_step_in, // pulse: this unit becomes lowest group
   input wire logic chain_inhibit_in, // higher unit wants service
   input wire logic irq_disable_in, // high: no requests at all
   output cpiu_pkg::cpiu_casc_out_s casc_out, // cascade outputs
   output logic lowest_group, // this unit is the lowest group
   output logic status_overflow, // status wrapped, interrupts off
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   output logic irq // level interrupt to software
);
   import cpiu_pkg::*;

   initial begin
      if (LEVELS != (1 << CPIU_VEC_W)) begin
         $error("cpiu_unit serves exactly eight levels");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // instruction decode

   logic [LEVELS-1:0] mask_ff, nxt_mask;
   logic [CPIU_VEC_W-1:0] status_ff, nxt_status;
   logic [CPIU_VEC_W-1:0] hold_ff;
   logic lowest_ff, vcen_ff, ovfl_ff, irqen_ff, step_ff;
   logic vec_drive_ff;

   wire instr_go = ~instr_accept_n;
   wire op_mclr = instr_go && (instr_field == CPIU_I_MASTER_CLR);
   wire op_clr_all = instr_go && (instr_field == CPIU_I_CLR_ALL);
   wire op_clr_mbus = instr_go && (instr_field == CPIU_I_CLR_MBUS);
   wire op_clr_mreg = instr_go && (instr_field == CPIU_I_CLR_MASKREG);
   wire op_clr_last = instr_go && (instr_field == CPIU_I_CLR_LAST);
   wire op_rd_vec = instr_go && (instr_field == CPIU_I_READ_VEC);
   wire op_rd_stat = instr_go && (instr_field == CPIU_I_READ_STAT);
   wire op_rd_mask = instr_go && (instr_field == CPIU_I_READ_MASK);
   wire op_set_mask = instr_go && (instr_field == CPIU_I_SET_MASK);
   wire op_ld_stat = instr_go && (instr_field == CPIU_I_LOAD_STAT);
   wire op_bclr_mask = instr_go && (instr_field == CPIU_I_BITCLR_MASK);
   wire op_bset_mask = instr_go && (instr_field == CPIU_I_BITSET_MASK);
   wire op_clr_mask = instr_go && (instr_field == CPIU_I_CLR_MASK);
   wire op_irq_off = instr_go && (instr_field == CPIU_I_IRQ_OFF);
   wire op_ld_mask = instr_go && (instr_field == CPIU_I_LOAD_MASK);
   wire op_irq_on = instr_go && (instr_field == CPIU_I_IRQ_ON);

   ////////////////////////////////////////////////////////////////////////////
   // request pins: three-stage synchroniser, change taken when stages 2 and 3 agree

   logic [LEVELS-1:0] sync1_ff, sync2_ff, sync3_ff, pin_ff;
   logic [LEVELS-1:0] nxt_pin;

   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1_ff <= '1;
         sync2_ff <= '1;
         sync3_ff <= '1;
         pin_ff <= '1;
      end else begin
         sync1_ff <= request_inputs_n;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         pin_ff <= nxt_pin;
      end
   end

   assign nxt_pin = (sync2_ff == sync3_ff) ? sync2_ff : pin_ff;
   wire [LEVELS-1:0] req_now = ~pin_ff;

   ////////////////////////////////////////////////////////////////////////////
   // per-level clears, pulse catchers and request register

   logic [LEVELS-1:0] latch_ff, reqreg_ff;
   logic [LEVELS-1:0] last_onehot;
   assign last_onehot = LEVELS'(1) << hold_ff;

   logic [LEVELS-1:0] clr_vec;
   assign clr_vec = ({LEVELS{op_mclr | op_clr_all}})
      | ({LEVELS{op_clr_mbus}} & mask_bus_in)
      | ({LEVELS{op_clr_mreg}} & mask_ff)
      | ({LEVELS{op_clr_last & vcen_ff}} & last_onehot);

   // a new request beats a clear in the same cycle, so no event is lost
   logic [LEVELS-1:0] nxt_latch, latch_q, nxt_reqreg;
   assign nxt_latch = req_now | (latch_ff & ~clr_vec);
   assign latch_q = catcher_bypass ? req_now : latch_ff;
   assign nxt_reqreg = latch_q & ~clr_vec;

   always_ff @(posedge mclk) begin
      if (rst) begin
         latch_ff <= '0;
         reqreg_ff <= '0;
      end else begin
         latch_ff <= nxt_latch;
         reqreg_ff <= nxt_reqreg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // masking, detect, priority encoder, comparator

   // a mask bit at one blocks its level
   logic [LEVELS-1:0] pending;
   assign pending = reqreg_ff & ~mask_ff;
   wire present = |pending;

   logic [CPIU_VEC_W-1:0] vec;
   always_comb begin
      vec = '0;
      for (int i = 0; i < LEVELS; i++) begin
         if (pending[i]) begin
            vec = CPIU_VEC_W'(i);
         end
      end
   end

   wire vec_ge_stat = (vec >= status_ff);
   // groups above the lowest accept every level; the lowest one compares
   wire level_ok = lowest_ff ? vec_ge_stat : 1'b1;
   wire grp_ok = group_select_in & irqen_ff & ~ovfl_ff & ~irq_disable_in;
   wire accept = present & level_ok & grp_ok;
   wire win = accept & ~chain_inhibit_in;

   assign casc_out.irq_request = win;
   assign casc_out.parallel_inhibit = accept;
   assign casc_out.chain_inhibit = accept | chain_inhibit_in;
   assign casc_out.group_step_out = step_ff;

   ////////////////////////////////////////////////////////////////////////////
   // mask, status, hold and flags

   logic [LEVELS-1:0] mask_mod;
   assign mask_mod = op_ld_mask ? mask_bus_in :
      op_set_mask ? '1 :
      (op_clr_mask | op_mclr) ? '0 :
      op_bset_mask ? (mask_ff | mask_bus_in) :
      op_bclr_mask ? (mask_ff & ~mask_bus_in) : mask_ff;
   assign nxt_mask = mask_mod;

   wire rd_ours = op_rd_vec & win;
   wire wrap = rd_ours & (vec == CPIU_VEC_TOP);
   assign nxt_status = op_mclr ? CPIU_STAT_RST :
      op_ld_stat ? status_bus_in :
      rd_ours ? (vec + CPIU_VEC_ONE) : status_ff;

   always_ff @(posedge mclk) begin
      if (rst) begin
         mask_ff <= CPIU_MASK_RST;
         status_ff <= CPIU_STAT_RST;
         hold_ff <= '0;
         vcen_ff <= 1'b0;
         ovfl_ff <= 1'b0;
         irqen_ff <= 1'b0;
         step_ff <= 1'b0;
         vec_drive_ff <= 1'b0;
      end else begin
         mask_ff <= nxt_mask;
         status_ff <= nxt_status;
         if (rd_ours) begin
            hold_ff <= vec;
         end
         if (op_rd_vec) begin
            vcen_ff <= win;
         end else if (op_mclr) begin
            vcen_ff <= 1'b0;
         end
         if (op_mclr | op_ld_stat) begin
            ovfl_ff <= 1'b0;
         end else if (wrap) begin
            ovfl_ff <= 1'b1;
         end
         if (op_irq_on) begin
            irqen_ff <= 1'b1;
         end else if (op_irq_off | op_mclr) begin
            irqen_ff <= 1'b0;
         end
         step_ff <= wrap;
         vec_drive_ff <= op_rd_vec;
      end
   end

   // every unit leaves reset as the lowest group: one strapped by
   // the parameter would need a clocked strap; here the step chain hands it over
   always_ff @(posedge mclk) begin
      if (rst) begin
         lowest_ff <= 1'b1;
      end else if (group_step_in) begin
         lowest_ff <= 1'b1;
      end else if (wrap) begin
         lowest_ff <= 1'b0;
      end
   end

   assign lowest_group = lowest_ff;
   assign status_overflow = ovfl_ff;
   assign mask_bus_out = mask_ff;
   assign mask_bus_oe = op_rd_mask;
   assign status_bus_out = status_ff;
   assign status_bus_oe = op_rd_stat;
   assign vector_out = hold_ff;
   assign vector_oe = vec_drive_ff & vcen_ff;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: event flags, event mask, state read-back

   logic [CPIU_EV_W-1:0] evt_ff, evmask_ff, nxt_evt;
   logic accept_d_ff;

   wire apb_wr = psel & penable & pwrite;
   wire sel_stat = (paddr == CPIU_A_EVT_STAT);
   wire sel_mask = (paddr == CPIU_A_EVT_MASK);
   wire sel_state = (paddr == CPIU_A_STATE);
   wire sel_level = (paddr == CPIU_A_LEVEL);
   wire mapped = sel_stat | sel_mask | sel_state | sel_level;

   logic [CPIU_EV_W-1:0] ev_set;
   assign ev_set[CPIU_EV_ACCEPT] = accept & ~accept_d_ff;
   assign ev_set[CPIU_EV_VREAD] = rd_ours;
   assign ev_set[CPIU_EV_OVFL] = wrap;
   // set beats a write-one-to-clear in the same cycle
   assign nxt_evt = ev_set | (evt_ff & ~({CPIU_EV_W{apb_wr & sel_stat}} & pwdata[CPIU_EV_W-1:0]));

   always_ff @(posedge mclk) begin
      if (rst) begin
         evt_ff <= '0;
         evmask_ff <= '0;
         accept_d_ff <= 1'b0;
      end else begin
         evt_ff <= nxt_evt;
         accept_d_ff <= accept;
         if (apb_wr & sel_mask) begin
            evmask_ff <= pwdata[CPIU_EV_W-1:0];
         end
      end
   end

   logic [31:0] state_word;
   always_comb begin
      state_word = '0;
      state_word[CPIU_ST_MASK_LSB +: LEVELS] = mask_ff;
      state_word[CPIU_ST_STAT_LSB +: CPIU_VEC_W] = status_ff;
      state_word[CPIU_ST_HOLD_LSB +: CPIU_VEC_W] = hold_ff;
      state_word[CPIU_ST_LOWEST] = lowest_ff;
      state_word[CPIU_ST_VCEN] = vcen_ff;
      state_word[CPIU_ST_OVFL] = ovfl_ff;
      state_word[CPIU_ST_IRQEN] = irqen_ff;
   end

   logic [31:0] level_word;
   assign level_word = {8'h00, pending, reqreg_ff, latch_ff};

   assign prdata = sel_stat ? 32'(evt_ff) :
      sel_mask ? 32'(evmask_ff) :
      sel_state ? state_word :
      sel_level ? level_word : 32'h0000_0000;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign irq = |(evt_ff & evmask_ff);
endmodule : cpiu_unit

// ==== cpiu_pkg.sv ====
/*
 package for the cascadable priority interrupt unit: instruction codes, widths,
 bus offsets, event bit positions and the cascade output carrier.
 assumes nothing of its surroundings.
*/
package cpiu_pkg;
   localparam int unsigned CPIU_LEVELS = 8;
   localparam int unsigned CPIU_VEC_W = 3;
   localparam int unsigned CPIU_INSTR_W = 4;
   localparam int unsigned CPIU_SYNC_STAGES = 3;

   // microinstruction encoding of the instruction field
   localparam logic [3:0] CPIU_I_MASTER_CLR = 4'h0;
   localparam logic [3:0] CPIU_I_CLR_ALL = 4'h1;
   localparam logic [3:0] CPIU_I_CLR_MBUS = 4'h2;
   localparam logic [3:0] CPIU_I_CLR_MASKREG = 4'h3;
   localparam logic [3:0] CPIU_I_CLR_LAST = 4'h4;
   localparam logic [3:0] CPIU_I_READ_VEC = 4'h5;
   localparam logic [3:0] CPIU_I_READ_STAT = 4'h6;
   localparam logic [3:0] CPIU_I_READ_MASK = 4'h7;
   localparam logic [3:0] CPIU_I_SET_MASK = 4'h8;
   localparam logic [3:0] CPIU_I_LOAD_STAT = 4'h9;
   localparam logic [3:0] CPIU_I_BITCLR_MASK = 4'ha;
   localparam logic [3:0] CPIU_I_BITSET_MASK = 4'hb;
   localparam logic [3:0] CPIU_I_CLR_MASK = 4'hc;
   localparam logic [3:0] CPIU_I_IRQ_OFF = 4'hd;
   localparam logic [3:0] CPIU_I_LOAD_MASK = 4'he;
   localparam logic [3:0] CPIU_I_IRQ_ON = 4'hf;

   // apb register byte offsets
   localparam logic [7:0] CPIU_A_EVT_STAT = 8'h00;
   localparam logic [7:0] CPIU_A_EVT_MASK = 8'h04;
   localparam logic [7:0] CPIU_A_STATE = 8'h08;
   localparam logic [7:0] CPIU_A_LEVEL = 8'h0c;

   // event bit positions (same layout in status and mask)
   localparam int unsigned CPIU_EV_ACCEPT = 0;
   localparam int unsigned CPIU_EV_VREAD = 1;
   localparam int unsigned CPIU_EV_OVFL = 2;
   localparam int unsigned CPIU_EV_W = 3;

   // field positions of the state word
   localparam int unsigned CPIU_ST_MASK_LSB = 0;
   localparam int unsigned CPIU_ST_STAT_LSB = 8;
   localparam int unsigned CPIU_ST_HOLD_LSB = 12;
   localparam int unsigned CPIU_ST_LOWEST = 16;
   localparam int unsigned CPIU_ST_VCEN = 17;
   localparam int unsigned CPIU_ST_OVFL = 18;
   localparam int unsigned CPIU_ST_IRQEN = 19;

   localparam logic [7:0] CPIU_MASK_RST = 8'h00;
   localparam logic [2:0] CPIU_STAT_RST = 3'h0;
   localparam logic [2:0] CPIU_VEC_TOP = 3'h7;
   localparam logic [2:0] CPIU_VEC_ONE = 3'h1;

   typedef struct packed {
      logic irq_request;      // this unit asks for service
      logic parallel_inhibit; // this unit has a pending accepted request
      logic chain_inhibit;    // inhibit passed down the ripple chain
      logic group_step_out;   // one-cycle pulse: status wrapped, advance group
   } cpiu_casc_out_s;
endpackage : cpiu_pkg

// ==== cpiu_checker.sv ====
/* port assertions for the priority interrupt unit.
 assumes binding onto cpiu_unit with its default eight levels. */
`timescale 1ns/1ps
module cpiu_checker
   import cpiu_pkg::*;
(
   input wire logic mclk, // clock
   input wire logic rst, // sync reset
   input wire logic instr_accept_n, // field valid low
   input wire logic [3:0] instr_field, // code
   input wire logic [7:0] mask_bus_in, // mask bus
   input wire logic [7:0] mask_bus_out, // mask reg
   input wire logic mask_bus_oe, // mask drive
   input wire logic [2:0] status_bus_in, // status bus
   input wire logic [2:0] status_bus_out, // status reg
   input wire logic status_bus_oe, // status drive
   input wire logic [2:0] vector_out, // held vector
   input wire logic vector_oe, // vector drive
   input wire logic chain_inhibit_in, // upstream busy
   input wire logic irq_disable_in, // block all
   input wire cpiu_pkg::cpiu_casc_out_s casc_out, // cascade outs
   input wire logic status_overflow // wrapped
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire cmd = !instr_accept_n;
   mask_drive_a: assert property (mask_bus_oe == (cmd && instr_field == CPIU_I_READ_MASK))
      else $error("mask bus enable wrong");
   stat_drive_a: assert property (status_bus_oe == (cmd && instr_field == CPIU_I_READ_STAT))
      else $error("status bus enable wrong");
   mask_load_a: assert property (cmd && instr_field == CPIU_I_LOAD_MASK |=> mask_bus_out == $past(mask_bus_in))
      else $error("mask load wrong");
   stat_load_a: assert property (cmd && instr_field == CPIU_I_LOAD_STAT
      |=> status_bus_out == $past(status_bus_in) && !status_overflow) else $error("status load wrong");
   idle_hold_a: assert property (instr_accept_n |=> $stable(mask_bus_out) && $stable(status_bus_out))
      else $error("state moved without instruction");
   vec_read_a: assert property (cmd && instr_field == CPIU_I_READ_VEC && casc_out.irq_request
      |=> vector_oe && status_bus_out == vector_out + CPIU_VEC_ONE && status_overflow == (vector_out == CPIU_VEC_TOP))
      else $error("vector read wrong");
   ovfl_block_a: assert property (status_overflow || irq_disable_in |-> !casc_out.parallel_inhibit)
      else $error("accepted while disabled");
   casc_gate_a: assert property (casc_out.chain_inhibit == (casc_out.parallel_inhibit || chain_inhibit_in)
      && casc_out.irq_request == (casc_out.parallel_inhibit && !chain_inhibit_in)) else $error("cascade gating wrong");
   step_pulse_a: assert property ($rose(status_overflow) |-> casc_out.group_step_out ##1 !casc_out.group_step_out)
      else $error("group step pulse wrong");
endmodule : cpiu_checker
bind cpiu_unit cpiu_checker u_chk (.mclk, .rst, .instr_accept_n, .instr_field, .mask_bus_in, .mask_bus_out,
   .mask_bus_oe, .status_bus_in, .status_bus_out, .status_bus_oe, .vector_out, .vector_oe, .chain_inhibit_in,
   .irq_disable_in, .casc_out, .status_overflow);

// ==== cpiu_ctrl_model.sv ====
/* microprogram controller model issuing interrupt microinstructions.
 assumes the bench resolves bus levels from the unit's output enables. */
`timescale 1ns/1ps
module cpiu_ctrl_model (
   input wire logic mclk, // clock
   output logic instr_accept_n, // low: field valid
   output logic [3:0] instr_field, // code
   output logic [7:0] mask_drv, // mask bus value
   output logic [2:0] stat_drv // status bus value
);
   initial begin
      instr_accept_n = 1'b1;
      instr_field = 4'h0;
      mask_drv = 8'h00;
      stat_drv = 3'h0;
   end
   task automatic issue(input logic [3:0] code, input logic [7:0] m, input logic [2:0] s);
      @(posedge mclk);
      instr_accept_n <= 1'b0;
      instr_field <= code;
      mask_drv <= m;
      stat_drv <= s;
      @(posedge mclk);
      instr_accept_n <= 1'b1;
      // field is shared with other units, so it never holds a stale code
      instr_field <= ~code;
      mask_drv <= ~m;
      stat_drv <= ~s;
   endtask : issue
endmodule : cpiu_ctrl_model

// ==== tb.sv ====
/* self-checking bench for the priority interrupt unit.
 assumes the checker is bound and the controller model drives instructions. */
`timescale 1ns/1ps
module tb;
   import cpiu_pkg::*;
   logic mclk = 1'b0, rst = 1'b1, bypass = 1'b0, chain_in = 1'b0, dis_in = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, lowest, ovfl, vec_oe, m_oe, s_oe;
   logic [7:0] req_n = 8'hff, paddr = 8'h00, m_out, m_drv;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] fld;
   logic [2:0] s_out, s_drv, vec;
   logic acc_n, er;
   cpiu_casc_out_s co;
   int n_fail = 0, comparisons = 0;
   wire [7:0] m_bus = m_oe ? m_out : m_drv;
   wire [2:0] s_bus = s_oe ? s_out : s_drv;
   always #50 mclk = ~mclk;
   cpiu_ctrl_model u_ctl (.mclk(mclk), .instr_accept_n(acc_n), .instr_field(fld), .mask_drv(m_drv), .stat_drv(s_drv));
   cpiu_unit u_dut (.mclk(mclk), .rst(rst), .instr_accept_n(acc_n), .instr_field(fld), .request_inputs_n(req_n),
      .catcher_bypass(bypass), .mask_bus_in(m_bus), .mask_bus_out(m_out), .mask_bus_oe(m_oe), .status_bus_in(s_bus),
      .status_bus_out(s_out), .status_bus_oe(s_oe), .vector_out(vec), .vector_oe(vec_oe), .group_select_in(1'b1),
      .group_step_in(1'b0), .chain_inhibit_in(chain_in), .irq_disable_in(dis_in), .casc_out(co), .lowest_group(lowest),
      .status_overflow(ovfl), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         n_fail++;
         report_and_stop();
      end
   endtask : apb
   task automatic settle;
      @(negedge mclk);
   endtask : settle
   task automatic pulse(input logic [7:0] lv);
      @(posedge mclk);
      req_n <= ~lv;
      repeat (4) @(posedge mclk);
      req_n <= 8'hff;
      repeat (8) @(posedge mclk);
   endtask : pulse
   task automatic t_reset;
      apb(1'b0, CPIU_A_STATE, 32'h0);
      chk("state", 32'h0001_0000, rd);
      $display("reset test done");
   endtask : t_reset
   task automatic t_mask;
      logic [3:0] op [6] = '{CPIU_I_LOAD_MASK, CPIU_I_BITSET_MASK, CPIU_I_BITCLR_MASK, CPIU_I_SET_MASK,
         CPIU_I_CLR_MASK, CPIU_I_READ_MASK};
      logic [7:0] mv [6] = '{8'ha5, 8'h0f, 8'ha0, 8'h00, 8'h00, 8'h00};
      logic [7:0] ex [6] = '{8'ha5, 8'haf, 8'h0f, 8'hff, 8'h00, 8'h00};
      for (int i = 0; i < 6; i++) begin
         u_ctl.issue(op[i], mv[i], 3'h0);
         settle();
         chk("mask", ex[i], m_out);
      end
      $display("mask test done");
   endtask : t_mask
   task automatic level_chk(input logic [7:0] e);
      apb(1'b0, CPIU_A_LEVEL, 32'h0);
      chk("request reg", e, rd[15:8]);
   endtask : level_chk
   task automatic t_vector;
      u_ctl.issue(CPIU_I_IRQ_ON, 8'h00, 3'h0);
      pulse(8'h24);
      u_ctl.issue(CPIU_I_READ_VEC, 8'h00, 3'h0);
      settle();
      chk("vector", 5, vec);
      chk("vector drive", 1, vec_oe);
      chk("status", 6, s_out);
      chk("accept below status", 0, co.parallel_inhibit);
      u_ctl.issue(CPIU_I_CLR_LAST, 8'h00, 3'h0);
      level_chk(8'h04);
      u_ctl.issue(CPIU_I_LOAD_STAT, 8'h00, 3'h0);
      u_ctl.issue(CPIU_I_READ_VEC, 8'h00, 3'h0);
      settle();
      chk("vector", 2, vec);
      u_ctl.issue(CPIU_I_READ_STAT, 8'h00, 3'h0);
      pulse(8'h0a);
      u_ctl.issue(CPIU_I_CLR_MBUS, 8'h02, 3'h0);
      level_chk(8'h0c);
      u_ctl.issue(CPIU_I_LOAD_MASK, 8'h08, 3'h0);
      u_ctl.issue(CPIU_I_CLR_MASKREG, 8'h00, 3'h0);
      level_chk(8'h04);
      u_ctl.issue(CPIU_I_READ_VEC, 8'h00, 3'h0);
      u_ctl.issue(CPIU_I_CLR_LAST, 8'h00, 3'h0);
      level_chk(8'h04);
      u_ctl.issue(CPIU_I_CLR_ALL, 8'h00, 3'h0);
      level_chk(8'h00);
      u_ctl.issue(CPIU_I_CLR_MASK, 8'h00, 3'h0);
      $display("vector test done");
   endtask : t_vector
   task automatic t_ovfl;
      apb(1'b1, CPIU_A_EVT_STAT, 32'h7);
      apb(1'b1, CPIU_A_EVT_MASK, 32'h4);
      pulse(8'h80);
      u_ctl.issue(CPIU_I_READ_VEC, 8'h00, 3'h0);
      settle();
      chk("vector", 7, vec);
      chk("status", 0, s_out);
      chk("overflow", 1, ovfl);
      chk("lowest", 0, lowest);
      repeat (2) settle();
      chk("irq", 1, irq);
      chk("accept on overflow", 0, co.parallel_inhibit);
      apb(1'b1, CPIU_A_EVT_STAT, 32'h4);
      settle();
      chk("irq", 0, irq);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 1, er);
      chk("unmapped data", 0, rd);
      u_ctl.issue(CPIU_I_LOAD_STAT, 8'h00, 3'h5);
      settle();
      chk("accept upper group", 1, co.parallel_inhibit);
      @(posedge mclk);
      chain_in <= 1'b1;
      settle();
      chk("request out", 0, co.irq_request);
      @(posedge mclk);
      dis_in <= 1'b1;
      settle();
      chk("accept disabled", 0, co.parallel_inhibit);
      @(posedge mclk);
      chain_in <= 1'b0;
      dis_in <= 1'b0;
      u_ctl.issue(CPIU_I_IRQ_OFF, 8'h00, 3'h0);
      settle();
      chk("accept off", 0, co.parallel_inhibit);
      u_ctl.issue(CPIU_I_MASTER_CLR, 8'h00, 3'h0);
      apb(1'b0, CPIU_A_STATE, 32'h0);
      chk("state", 0, rd & 32'h000c_07ff);
      $display("overflow test done");
   endtask : t_ovfl
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_mask();
      t_vector();
      t_ovfl();
      report_and_stop();
   end
endmodule : tb
